/* pic_pkg.sv */
/*
  Package for the prioritised interrupt controller: source counts, vector
  numbers, priority-register bit positions, reset values and carrier structs.
  Assumes one synchronous clock domain and an exception sequencer on the far side.
*/
package pic_pkg;

  // Number of request lines: 5 pins, 15 timer, 4 serial, 1 converter.
  localparam int PIC_NSRC = 25;

  // Vector number width and vector address width.
  localparam int PIC_VW = 8;
  localparam int PIC_AW = 16;

  // Non-maskable vector number.
  localparam logic [7:0] PIC_NMI_VEC = 8'h07;

  // Vector number of each source, in default order.
  localparam logic [7:0] PIC_VEC [PIC_NSRC] = '{
    8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10,
    8'h18, 8'h19, 8'h1a, 8'h1c, 8'h1d, 8'h1e, 8'h20, 8'h21, 8'h22,
    8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h2a,
    8'h34, 8'h35, 8'h36, 8'h37,
    8'h3c};

  // Which priority bit (0..15, b in the high byte) governs each source.
  localparam logic [3:0] PIC_PBIT [PIC_NSRC] = '{
    4'h7, 4'h6, 4'h5, 4'h5, 4'h4,
    4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0,
    4'hf, 4'hf, 4'hf, 4'he, 4'he, 4'he,
    4'hb, 4'hb, 4'hb, 4'hb,
    4'h9};

  // Register addresses on the register port.
  localparam logic [1:0] PIC_ADDR_PRIO_A = 2'h0;
  localparam logic [1:0] PIC_ADDR_PRIO_B = 2'h1;
  localparam logic [1:0] PIC_ADDR_SYSCTL = 2'h2;
  localparam logic [1:0] PIC_ADDR_STATUS = 2'h3;

  // Reset values.
  localparam logic [7:0] PIC_PRIO_RST   = 8'h00;
  localparam logic [7:0] PIC_SYSCTL_RST = 8'h08;

  // System control register field positions.
  localparam int PIC_SC_NMI_EDGE = 2;
  localparam int PIC_SC_SCHEME   = 3;

  // Decision latency in states.
  localparam logic [1:0] PIC_DEC_EXT = 2'h2;
  localparam logic [1:0] PIC_DEC_INT = 2'h1;

  // CPU mask word toward the controller.
  typedef struct packed {
    logic global_mask;
    logic secondary_mask_bit;
  } pic_mask_s;

  // Request offered to the CPU.
  typedef struct packed {
    logic              valid;
    logic              nmi;
    logic [PIC_VW-1:0] vec_num;
    logic [PIC_AW-1:0] vec_addr;
  } pic_req_s;

endpackage : pic_pkg

/* pic_ctrl.sv */
/*
  Prioritised interrupt controller core with its register port.
  Assumes the exception sequencer saves context, sets the mask bits after
  acceptance, honours instruction-boundary rules and pulses ack on acceptance.
*/
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Scheme one: global mask gates all maskable.
// - Scheme zero: global mask gates level zero.
// - Scheme zero: level one needs both masks.
// - Non-maskable taken always except reset, standby.
// - Source forwarded only when its enable set.
// - Higher programmed level wins; others stay pending.
// - Equal levels fall back to default order.
// - Vector address given; CPU fetches from it.
// - Four-byte or two-byte vector entries by mode.
// - Timer channels 0-2 vectors and priority bits.
// - Timer channels 3-4 vectors and priority bits.
// - Serial 52-55 bit 3; converter 60 bit 1.
// - Decision two states external, one internal.
// - Clearing takes effect after instruction completes.
// - Smaller vector number wins by default.
// - Priority registers reset to zero.
// - Non-maskable uses vector 7, edge selectable.
// - Pin interrupts use vectors 12 to 16.
module pic_ctrl #(
  parameter int NSRC = 25
) (
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  // Chip state.
  input  wire logic                   hw_standby,
  input  wire logic                   advanced_mode,
  // Interrupt sources.
  input  wire logic                   nmi_pin,
  input  wire logic [NSRC-1:0]        src_cond,
  input  wire logic [NSRC-1:0]        src_enable,
  // CPU mask bits and acceptance.
  input  wire pic_pkg::pic_mask_s     cpu_mask,
  input  wire logic                   cpu_ack,
  // Offered request.
  output pic_pkg::pic_req_s           irq_out,
  // Register port.
  input  wire logic [1:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata
);
  import pic_pkg::*;

  initial begin
    if (NSRC != PIC_NSRC) $error("pic_ctrl: NSRC must match the source table");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0] prio_a_q, prio_a_d;   // Priority select A.
  logic [7:0] prio_b_q, prio_b_d;   // Priority select B.
  logic [7:0] sysctl_q, sysctl_d;   // System control register.
  logic [7:0] rdata_q,  rdata_d;    // Read data, one cycle after strobe.
  pic_req_s   irq_q,    irq_d;      // Offered request, read back as status.

  // Register writes and read mux.
  always_comb begin
    prio_a_d = prio_a_q;
    prio_b_d = prio_b_q;
    sysctl_d = sysctl_q;
    rdata_d  = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        PIC_ADDR_PRIO_A: prio_a_d = reg_wdata;
        PIC_ADDR_PRIO_B: prio_b_d = reg_wdata;
        PIC_ADDR_SYSCTL: sysctl_d = reg_wdata;
        default:         ;  // Status is read-only.
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        PIC_ADDR_PRIO_A: rdata_d = prio_a_q;
        PIC_ADDR_PRIO_B: rdata_d = prio_b_q;
        PIC_ADDR_SYSCTL: rdata_d = sysctl_q;
        PIC_ADDR_STATUS: rdata_d = irq_q.vec_num;
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  // Register state; standby reinitialises like reset.
  always_ff @(posedge ref_clk) begin
    if (srst || hw_standby) begin
      prio_a_q <= PIC_PRIO_RST;
      prio_b_q <= PIC_PRIO_RST;
      sysctl_q <= PIC_SYSCTL_RST;
      rdata_q  <= 8'h00;
    end else begin
      prio_a_q <= prio_a_d;
      prio_b_q <= prio_b_d;
      sysctl_q <= sysctl_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Non-maskable edge detection.

  logic nmi_prev_q, nmi_prev_d;   // Previous pin level.
  logic nmi_pend_q, nmi_pend_d;   // Latched non-maskable request.
  logic nmi_edge;                 // Selected edge seen this cycle.
  logic nmi_taken;                // Accepted by the CPU this cycle.

  // Edge select: 1 rising, 0 falling; a new edge wins over the clear.
  always_comb begin
    nmi_prev_d = nmi_pin;
    nmi_edge   = sysctl_q[PIC_SC_NMI_EDGE] ? (nmi_pin && !nmi_prev_q)
                                           : (!nmi_pin && nmi_prev_q);
    nmi_taken  = cpu_ack && irq_q.valid && irq_q.nmi;
    nmi_pend_d = nmi_edge || (nmi_pend_q && !nmi_taken);
  end

  // Pending flag is held clear in reset and standby.
  always_ff @(posedge ref_clk) begin
    if (srst || hw_standby) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_prev_d;
      nmi_pend_q <= nmi_pend_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-source request, level and mask.

  logic [NSRC-1:0] req;     // Enabled request.
  logic [NSRC-1:0] lvl;     // Programmed level.
  logic [NSRC-1:0] open_s;  // Not masked.
  logic [15:0]     prio_ab;

  assign prio_ab = {prio_b_q, prio_a_q};

  // Each source reads its level bit from the table.
  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_src
      assign req[i] = src_cond[i] && src_enable[i];
      assign lvl[i] = prio_ab[PIC_PBIT[i]];
      assign open_s[i] = sysctl_q[PIC_SC_SCHEME]
        ? !cpu_mask.global_mask
        : (lvl[i] ? !(cpu_mask.global_mask && cpu_mask.secondary_mask_bit)
                  : !cpu_mask.global_mask);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration.

  logic              win_found;
  logic              win_ext;
  logic [PIC_VW-1:0] win_vec;

  // Level-one pass first, then level zero; lowest index (smallest vector) first.
  always_comb begin
    win_found = 1'b0;
    win_ext   = 1'b0;
    win_vec   = '0;
    for (int p = 1; p >= 0; p--) begin
      for (int i = 0; i < NSRC; i++) begin
        if (req[i] && open_s[i] && (lvl[i] == p[0]) && !win_found) begin
          win_found = 1'b1;
          win_ext   = (i < 5);
          win_vec   = PIC_VEC[i];
        end
      end
      // The upward scan keeps the first hit, the smallest vector number.
      if (win_found) break;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offer state machine.

  typedef enum logic [1:0] {PIC_IDLE, PIC_DECIDE, PIC_OFFER} pic_st_e;

  pic_st_e           st_q, st_d;
  logic [1:0]        cnt_q, cnt_d;   // Decision states remaining.
  function automatic logic [PIC_AW-1:0] vaddr(input logic [PIC_VW-1:0] v,
                                               input logic adv);
    vaddr = adv ? {6'h00, v, 2'b00} : {7'h00, v, 1'b0};
  endfunction : vaddr

  // Decide, present, hold until acceptance.
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    irq_d = irq_q;
    case (st_q)
      PIC_IDLE: begin
        if (nmi_pend_q || win_found) begin
          st_d  = PIC_DECIDE;
          cnt_d = (nmi_pend_q || win_ext) ? PIC_DEC_EXT - 2'h1
                                          : PIC_DEC_INT - 2'h1;
        end
      end
      PIC_DECIDE: begin
        if (cnt_q != 2'h0) begin
          cnt_d = cnt_q - 2'h1;
        end else if (nmi_pend_q) begin
          st_d  = PIC_OFFER;
          irq_d = '{valid: 1'b1, nmi: 1'b1, vec_num: PIC_NMI_VEC,
                    vec_addr: vaddr(PIC_NMI_VEC, advanced_mode)};
        end else if (win_found) begin
          st_d  = PIC_OFFER;
          irq_d = '{valid: 1'b1, nmi: 1'b0, vec_num: win_vec,
                    vec_addr: vaddr(win_vec, advanced_mode)};
        end else begin
          st_d = PIC_IDLE;   // Request withdrew during decision.
        end
      end
      PIC_OFFER: begin
        if (cpu_ack) begin
          st_d  = PIC_IDLE;
          irq_d = '0;
        end
      end
      default: begin
        st_d  = PIC_IDLE;
        irq_d = '0;
      end
    endcase
  end

  // Offer registers.
  always_ff @(posedge ref_clk) begin
    if (srst || hw_standby) begin
      st_q  <= PIC_IDLE;
      cnt_q <= 2'h0;
      irq_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      irq_q <= irq_d;
    end
  end

  assign irq_out = irq_q;

endmodule : pic_ctrl

/* pic_ctrl_props.sv */
/* Port checker for pic_ctrl: offer holding, vector address, masking, reset.
   Assumes one clock, pic_pkg, and a bind to every pic_ctrl instance. */
`timescale 1ns/1ps
module pic_ctrl_chk
  import pic_pkg::*;
#(parameter int NSRC = 25)
(
  // Clock, reset and chip state.
  input wire logic                ref_clk,
  input wire logic                srst,
  input wire logic                hw_standby,
  input wire logic                advanced_mode,
  // CPU side.
  input wire pic_pkg::pic_mask_s  cpu_mask,
  input wire logic                cpu_ack,
  input wire pic_pkg::pic_req_s   irq_out,
  // Register port.
  input wire logic [1:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic [7:0]          reg_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic sch_q;  // Scheme select as last written; standby restores it.
  always_ff @(posedge ref_clk) begin
    if (srst || hw_standby) sch_q <= PIC_SYSCTL_RST[PIC_SC_SCHEME];
    else if (reg_wr && reg_addr == PIC_ADDR_SYSCTL) sch_q <= reg_wdata[PIC_SC_SCHEME];
  end
  property p_hold; irq_out.valid && !cpu_ack && !hw_standby |=> $stable(irq_out); endproperty
  a_hold: assert property (p_hold) else $error("offer moved before acceptance");
  property p_clr; irq_out.valid && cpu_ack |=> !irq_out.valid; endproperty
  a_clr: assert property (p_clr) else $error("offer kept after acceptance");
  property p_adv; irq_out.valid && advanced_mode |-> irq_out.vec_addr == {6'h0, irq_out.vec_num, 2'h0}; endproperty
  a_adv: assert property (p_adv) else $error("wide vector address wrong");
  property p_nor; irq_out.valid && !advanced_mode |-> irq_out.vec_addr == {7'h0, irq_out.vec_num, 1'h0}; endproperty
  a_nor: assert property (p_nor) else $error("narrow vector address wrong");
  property p_nmi; irq_out.valid |-> irq_out.nmi == (irq_out.vec_num == PIC_NMI_VEC); endproperty
  a_nmi: assert property (p_nmi) else $error("non-maskable vector wrong");
  property p_stby; hw_standby |=> !irq_out.valid; endproperty
  a_stby: assert property (p_stby) else $error("offer during standby");
  property p_rst; disable iff (1'b0) srst |=> !irq_out.valid && reg_rdata == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_mask1; $rose(irq_out.valid) && !irq_out.nmi && sch_q |-> !$past(cpu_mask.global_mask); endproperty
  a_mask1: assert property (p_mask1) else $error("masked offer in scheme one");
  property p_both; $rose(irq_out.valid) && !irq_out.nmi
    |-> !($past(cpu_mask.global_mask) && $past(cpu_mask.secondary_mask_bit)); endproperty
  a_both: assert property (p_both) else $error("offer with both masks set");
  c_ack: cover property (irq_out.valid && cpu_ack);
  c_nmi: cover property (irq_out.valid && irq_out.nmi);
  c_nor: cover property (irq_out.valid && !advanced_mode);
endmodule : pic_ctrl_chk
bind pic_ctrl pic_ctrl_chk #(.NSRC(NSRC)) u_chk (.ref_clk, .srst, .hw_standby, .advanced_mode,
  .cpu_mask, .cpu_ack, .irq_out, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata);

/* pic_cpu_seq.sv */
/* Exception sequencer model: accepts an offer after the current instruction.
   Assumes one clock; the bench loads mask words and the instruction length. */
`timescale 1ns/1ps
module pic_cpu_seq
  import pic_pkg::*;
(
  // Clock and reset.
  input  wire logic                ref_clk,
  input  wire logic                srst,
  // Controller side.
  input  wire pic_pkg::pic_req_s   irq_out,
  output logic                     cpu_ack,
  output pic_pkg::pic_mask_s       cpu_mask,
  // Bench control and observation.
  input  wire logic                scheme,
  input  wire logic [3:0]          wait_n,
  input  wire logic                mask_ld,
  input  wire pic_pkg::pic_mask_s  mask_in,
  output logic [7:0]               taken_vec
);
  // Cycles spent finishing the current instruction; wait_n also stands for an
  // inhibiting control instruction plus its successor, or a running block move.
  logic [3:0] cnt_q;
  // Acceptance waits out the instruction, then records the vector, sets the global mask and, in scheme zero only, the secondary mask.
  always_ff @(posedge ref_clk) begin
    cpu_ack <= 1'b0;
    if (srst) begin
      cnt_q     <= '0;
      cpu_mask  <= '0;
      taken_vec <= '0;
    end else if (mask_ld) begin
      cpu_mask <= mask_in;
    end else if (irq_out.valid && !cpu_ack) begin
      if (cnt_q == wait_n) begin
        cpu_ack   <= 1'b1;
        taken_vec <= irq_out.vec_num;
        cpu_mask  <= {1'b1, ~scheme | cpu_mask.secondary_mask_bit};
        cnt_q     <= '0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule : pic_cpu_seq

/* prioritised_interrupt_controller_tb_top.sv */
/* Bench for pic_ctrl: registers, vector table, priority, masking, latency.
   Assumes pic_pkg, the sequencer model and the bound checker. */
`timescale 1ns/1ps
module prioritised_interrupt_controller_tb_top;
  import pic_pkg::*;
  logic ref_clk, srst, hw_standby, advanced_mode, nmi_pin, cpu_ack, reg_wr, reg_rd, scheme, mask_ld;
  logic [24:0] src_cond, src_enable;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, taken_vec, v, d;
  logic [3:0]  wait_n;
  pic_mask_s   cpu_mask, mask_in;
  pic_req_s    irq_out;
  int          n_fail, comparisons, n, n_ext;
  pic_ctrl dut (.ref_clk, .srst, .hw_standby, .advanced_mode, .nmi_pin, .src_cond, .src_enable,
    .cpu_mask, .cpu_ack, .irq_out, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  pic_cpu_seq cpu (.ref_clk, .srst, .irq_out, .cpu_ack, .cpu_mask, .scheme, .wait_n, .mask_ld,
    .mask_in, .taken_vec);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(logic [1:0] a, logic [7:0] x);
    reg_addr <= a; reg_wdata <= x; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(logic [1:0] a);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
  endtask : rd
  function automatic logic [7:0] exp_vec(int i);
    if (i < 5) return 8'(12 + i);
    if (i < 14) return 8'(24 + (i - 5) / 3 * 4 + (i - 5) % 3);
    if (i < 20) return 8'(36 + (i - 14) / 3 * 4 + (i - 14) % 3);
    return (i < 24) ? 8'(32 + i) : 8'h3c;
  endfunction : exp_vec
  // Loads masks, raises conditions, takes the offer (ff when none) and drops them.
  task automatic serve(logic [24:0] c, logic [24:0] e, pic_mask_s m);
    mask_in <= m; mask_ld <= 1'b1;
    @(posedge ref_clk);
    mask_ld <= 1'b0; src_cond <= c; src_enable <= e;
    n = 0;
    while (irq_out.valid !== 1'b1 && n < 12) begin
      @(negedge ref_clk);
      n++;
    end
    v = (irq_out.valid === 1'b1) ? irq_out.vec_num : 8'hff;
    repeat (12) if (irq_out.valid === 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    src_cond <= '0;
    @(posedge ref_clk);
  endtask : serve
  task automatic t_regs;
    rd(PIC_ADDR_PRIO_A); chk("prio a reset", 16'h0, {8'h0, d});
    rd(PIC_ADDR_PRIO_B); chk("prio b reset", 16'h0, {8'h0, d});
    rd(PIC_ADDR_SYSCTL); chk("sysctl reset", {8'h0, PIC_SYSCTL_RST}, {8'h0, d});
    wr(PIC_ADDR_PRIO_B, 8'hc2); rd(PIC_ADDR_PRIO_B); chk("prio b", 16'hc2, {8'h0, d});
    wr(PIC_ADDR_STATUS, 8'h55); rd(PIC_ADDR_STATUS); chk("status", 16'h0, {8'h0, d});
    wr(PIC_ADDR_PRIO_B, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_vec;
    for (int i = 0; i < 25; i++) begin
      advanced_mode <= i[0];
      wait_n <= 4'(i % 4);
      serve(25'h1 << i, 25'h1 << i, 2'b00);
      if (i == 0) n_ext = n;
      chk("vector", {8'h0, exp_vec(i)}, {8'h0, v});
      chk("taken", {8'h0, exp_vec(i)}, {8'h0, taken_vec});
      if (i == 5) chk("decision states", 16'(n_ext), 16'(n + 1));
    end
    serve(25'h20, 25'h0, 2'b00); chk("disabled source", 16'hff, {8'h0, v});
    $display("test vectors done");
  endtask : t_vec
  task automatic t_prio;
    serve(25'h1000001, 25'h1000001, 2'b00); chk("default order", 16'h0c, {8'h0, v});
    wr(PIC_ADDR_PRIO_B, 8'h02);
    serve(25'h1000001, 25'h1000001, 2'b00); chk("level one wins", 16'h3c, {8'h0, v});
    wr(PIC_ADDR_PRIO_A, 8'h80);
    serve(25'h1000001, 25'h1000001, 2'b00); chk("tie order", 16'h0c, {8'h0, v});
    serve(25'h0f00000, 25'h0f00000, 2'b00); chk("serial order", 16'h34, {8'h0, v});
    wr(PIC_ADDR_PRIO_A, 8'h00);
    $display("test priority done");
  endtask : t_prio
  task automatic t_mask;
    serve(25'h1, 25'h1, 2'b10); chk("scheme one mask", 16'hff, {8'h0, v});
    wr(PIC_ADDR_SYSCTL, 8'h00);
    scheme <= 1'b0;
    serve(25'h1000001, 25'h1000001, 2'b10); chk("level one open", 16'h3c, {8'h0, v});
    serve(25'h1, 25'h1, 2'b10); chk("level zero masked", 16'hff, {8'h0, v});
    serve(25'h1000000, 25'h1000000, 2'b11); chk("both masks", 16'hff, {8'h0, v});
    serve(25'h1, 25'h1, 2'b01); chk("level zero open", 16'h0c, {8'h0, v});
    nmi_pin <= 1'b0;
    serve('0, '0, 2'b11); chk("non-maskable", {8'h0, PIC_NMI_VEC}, {8'h0, v});
    nmi_pin <= 1'b1; hw_standby <= 1'b1;
    @(posedge ref_clk);
    nmi_pin <= 1'b0;
    serve('0, '0, 2'b11); chk("standby edge", 16'hff, {8'h0, v});
    hw_standby <= 1'b0;
    $display("test masking done");
  endtask : t_mask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    {srst, hw_standby, advanced_mode, reg_wr, reg_rd, mask_ld} = 6'h20;
    {nmi_pin, scheme} = 2'h3;
    {src_cond, src_enable, reg_addr, reg_wdata, wait_n, mask_in} = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_regs; t_vec; t_prio; t_mask;
    tally_and_finish;
  end
  // Cuts a hang short well past the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    tally_and_finish;
  end
endmodule : prioritised_interrupt_controller_tb_top
